// ==== logic/fbpe_map.svh ====
// Constants for the flash buffer-program and erase command block.
// Included by the package and the design files; holds definitions only.
`ifndef FBPE_MAP_SVH
`define FBPE_MAP_SVH
`define FBPE_AW          23
`define FBPE_DW          16
`define FBPE_OFF_HI      11
`define FBPE_OFF_SETUP   12'h555
`define FBPE_OFF_CNT     12'h2aa
`define FBPE_CMD_BUF     16'h0025
`define FBPE_CMD_COMMIT  16'h0029
`define FBPE_CMD_ESETUP  16'h0080
`define FBPE_CMD_SEC_ERS 16'h0030
`define FBPE_CMD_CHIP_ERS 16'h0010
`define FBPE_CMD_CLR_STS 16'h0071
`define FBPE_CMD_RD_STS  16'h0070
`define FBPE_CMD_SUSP    16'h00b0
`define FBPE_CMD_RESUME  16'h00d0
`define FBPE_CNT_W       5
`define FBPE_BUF_WORDS   32
`define FBPE_PAGE_HI     22
`define FBPE_PAGE_LO     5
`define FBPE_SEC_HI      22
`define FBPE_SEC_LO      19
`define FBPE_NSEC        16
`define FBPE_MEM_WORDS   256
`define FBPE_ST_RDY      7
`define FBPE_ST_ESUSP    6
`define FBPE_ST_EFAIL    5
`define FBPE_ST_PFAIL    4
`define FBPE_ST_PSUSP    2
`define FBPE_ST_PROT     1
`define FBPE_TMR_W       16
`define FBPE_PGM_CYC     16'd400
`define FBPE_PGM_ACC_CYC 16'd100
`define FBPE_SE_CYC      16'd2000
`define FBPE_SE_ACC_CYC  16'd500
`define FBPE_CE_CYC      16'd4000
`define FBPE_CLK_NS      40
`define FBPE_BOOST_NS    1000
`define FBPE_BOOST_CYC   ((`FBPE_BOOST_NS + `FBPE_CLK_NS - 1) / `FBPE_CLK_NS)
`define FBPE_REG_ADDR    8'h00
`define FBPE_REG_DATA    8'h04
`define FBPE_REG_CTRL    8'h08
`define FBPE_REG_STAT    8'h0c
`define FBPE_REG_RDAT    8'h10
`define FBPE_CTRL_BOOST  0
`define FBPE_CTRL_HWRST  1
`define FBPE_STAT_BRDY   8
`define FBPE_STAT_BUSY   9
`endif

// ==== logic/fbpe_pkg.sv ====
// Types shared by both ends of the flash command link.
// Assumes fbpe_map.svh is on the include path.
`include "fbpe_map.svh"
package fbpe_pkg;
    // Command interpreter states, one-hot
    typedef enum logic [9:0] {
        FBPE_IDLE    = 10'h001,
        FBPE_BCNT    = 10'h002,
        FBPE_BLOAD   = 10'h004,
        FBPE_BCOMMIT = 10'h008,
        FBPE_PBUSY   = 10'h010,
        FBPE_PSUSP   = 10'h020,
        FBPE_ESETUP  = 10'h040,
        FBPE_SEBUSY  = 10'h080,
        FBPE_SESUSP  = 10'h100,
        FBPE_CEBUSY  = 10'h200
    } fbpe_state_t;
    typedef logic [`FBPE_AW-1:0] fbpe_addr_t;
    typedef logic [`FBPE_DW-1:0] fbpe_word_t;
endpackage

// ==== logic/fbpe_if.sv ====
// Link between the memory controller and the flash bank.
// Both ends run on the same hclk; no signal here needs a synchroniser.
`timescale 1ns/1ps
interface fbpe_if;
    import fbpe_pkg::*;
    logic       wr_stb;             // One-cycle command write strobe
    fbpe_addr_t wr_addr;            // Command write address
    fbpe_word_t wr_data;            // Command write data
    logic       hw_reset;           // Hardware reset pulse, active high
    logic       boost_hv;           // High-voltage level on protect_boost_pin
    fbpe_addr_t rd_addr;            // Array read address
    fbpe_word_t rd_data;            // Array read data
    logic [7:0] status;             // Status register image
    logic       busy;               // Bank running an embedded operation
    modport dev  (input wr_stb, wr_addr, wr_data, hw_reset, boost_hv, rd_addr,
                  output rd_data, status, busy);
    modport host (output wr_stb, wr_addr, wr_data, hw_reset, boost_hv, rd_addr,
                  input rd_data, status, busy);
endinterface

// ==== logic/fbpe_timer.sv ====
// Down counter that times an embedded operation.
// Assumes load and run come from logic on the same clock.
`timescale 1ns/1ps
`include "fbpe_map.svh"
module fbpe_timer
    import fbpe_pkg::*;
(
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic                  load,
    input  wire logic [`FBPE_TMR_W-1:0] load_val,
    input  wire logic                  run,
    output logic                       done
);
    logic [`FBPE_TMR_W-1:0] cnt_r;  // Cycles left

    // Holds while run is low, so a suspend simply freezes the count
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r <= '0;
        end else if (load) begin
            cnt_r <= load_val;
        end else if (run && cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    // Pulse in the last counted cycle
    assign done = run && (cnt_r == `FBPE_TMR_W'(1));
endmodule // fbpe_timer

// ==== logic/fbpe_dev.sv ====
// Flash bank end: command decoder, write buffer, erase control, array model.
// Assumes the controller end drives the link on the same hclk.
// Summary of operation
// R01 - Buffer load holds at most 32 words
// R02 - 0025h at sector plus 555h starts load
// R03 - 2AAh write stores word count minus one
// R04 - First load fixes page, later loads match
// R05 - Off-page load aborts, sets status bit 4
// R06 - Other command after count set aborts; code takes on-page writes as loads until the last load
// R07 - Clear-status returns status bit 4 to zero
// R08 - Commit 0029h must follow last load
// R09 - Commit makes bank busy, then idle
// R10 - Id, config, secure functions off while programming
// R11 - Reprogramming allowed; bits only cleared
// R12 - Buffer program can suspend and resume
// R13 - 80h then 30 erases sector to ones
// R14 - Protected sector: no erase, status bit 1
// R15 - Sector erase ignores all but suspend, status
// R16 - 80h then 10h erases whole array
// R17 - Chip erase refused if any sector locked
// R18 - Chip erase accepts status read only
// R19 - High voltage on boost pin accelerates programming
// R20 - Host raises boost 1 us before erase
// R21 - Accelerated protected erase sets bits 5, 1; code sets bit 5 only for sector erase, chip erase sets bit 1 alone
// R22 - Host polls bits 7, 5, 1 for completion
// R23 - Programming ignores all but status, reset, suspend
`timescale 1ns/1ps
`include "fbpe_map.svh"
module fbpe_dev
    import fbpe_pkg::*;
(
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    fbpe_if.dev                        lnk,
    input  wire logic [`FBPE_NSEC-1:0] prot_sectors,
    output logic                       secure_cfg_en
);
    fbpe_state_t state_r;           // Interpreter state
    fbpe_state_t state_nxt;         // Next state
    logic        pfail_r;           // Program abort flag, status bit 4
    logic        efail_r;           // Erase failure flag, status bit 5
    logic        prot_r;            // Protect refusal flag, status bit 1
    logic [`FBPE_CNT_W-1:0] count_r;   // Expected loads minus one
    logic [`FBPE_CNT_W:0]   loads_r;   // Loads taken so far
    logic [`FBPE_PAGE_HI:`FBPE_PAGE_LO] page_r;   // Selected buffer page
    logic [`FBPE_SEC_HI-`FBPE_SEC_LO:0] sec_r;    // Sector of the operation
    fbpe_word_t  buf_r [`FBPE_BUF_WORDS];          // Write buffer
    logic [`FBPE_BUF_WORDS-1:0] vld_r;             // Buffer words loaded
    fbpe_word_t  mem_r [`FBPE_MEM_WORDS];          // Array model window
    logic [7:0]  status_r;          // Registered status image
    fbpe_word_t  rd_data_r;         // Registered read data
    logic        cfg_en_r;          // Registered aux function enable

    // Command decode
    wire [`FBPE_OFF_HI:0] off      = lnk.wr_addr[`FBPE_OFF_HI:0];
    wire at_setup   = off == `FBPE_OFF_SETUP;
    wire at_cnt     = off == `FBPE_OFF_CNT;
    wire w          = lnk.wr_stb;
    wire cmd_buf    = w && at_setup && lnk.wr_data == `FBPE_CMD_BUF;        // [R02]
    wire cmd_commit = w && at_setup && lnk.wr_data == `FBPE_CMD_COMMIT;
    wire cmd_esetup = w && at_setup && lnk.wr_data == `FBPE_CMD_ESETUP;
    wire cmd_se     = w && at_cnt && lnk.wr_data == `FBPE_CMD_SEC_ERS;
    wire cmd_ce     = w && at_cnt && lnk.wr_data == `FBPE_CMD_CHIP_ERS;
    wire cmd_clr    = w && lnk.wr_data == `FBPE_CMD_CLR_STS;
    wire cmd_susp   = w && lnk.wr_data == `FBPE_CMD_SUSP;
    wire cmd_resume = w && lnk.wr_data == `FBPE_CMD_RESUME;
    wire [`FBPE_SEC_HI-`FBPE_SEC_LO:0] wr_sec = lnk.wr_addr[`FBPE_SEC_HI:`FBPE_SEC_LO];
    wire prot_hit   = prot_sectors[wr_sec];
    wire any_prot   = |prot_sectors;
    wire page_hit   = lnk.wr_addr[`FBPE_PAGE_HI:`FBPE_PAGE_LO] == page_r;
    wire first_load = loads_r == '0;
    wire cnt_ok     = lnk.wr_data < `FBPE_DW'(`FBPE_BUF_WORDS);
    wire last_load  = loads_r == {1'b0, count_r};
    wire tmr_done;
    wire busy_st    = state_r inside {FBPE_PBUSY, FBPE_SEBUSY, FBPE_CEBUSY};

    // Events and timer load from the decoder
    logic abort_ev;                 // Buffer sequence aborted
    logic prot_ev;                  // Erase refused for protection
    logic acc_prot_ev;              // Sector erase refusal under boost voltage
    logic tmr_load;                 // Start an embedded operation
    logic [`FBPE_TMR_W-1:0] tmr_val;   // Its duration

    // Next state and event decode
    always_comb begin
        state_nxt   = state_r;
        abort_ev    = 1'b0;
        prot_ev     = 1'b0;
        acc_prot_ev = 1'b0;
        tmr_load    = 1'b0;
        tmr_val     = `FBPE_PGM_CYC;
        unique case (state_r)
            FBPE_IDLE: begin
                if (cmd_buf) begin
                    state_nxt = FBPE_BCNT;
                end else if (cmd_esetup) begin
                    state_nxt = FBPE_ESETUP;
                end
            end
            FBPE_BCNT: begin
                if (w && at_cnt && cnt_ok) begin
                    state_nxt = FBPE_BLOAD;                                 // [R03]
                end else if (w) begin
                    // Oversized count or stray write kills the sequence
                    state_nxt = FBPE_IDLE;                                  // [R01]
                    abort_ev  = 1'b1;
                end
            end
            FBPE_BLOAD: begin
                if (w && !first_load && !page_hit) begin
                    state_nxt = FBPE_IDLE;                                  // [R05]
                    abort_ev  = 1'b1;
                end else if (w && last_load) begin
                    state_nxt = FBPE_BCOMMIT;
                end
            end
            FBPE_BCOMMIT: begin
                if (cmd_commit) begin
                    state_nxt = FBPE_PBUSY;                                 // [R09]
                    tmr_load  = 1'b1;
                    tmr_val   = lnk.boost_hv ? `FBPE_PGM_ACC_CYC : `FBPE_PGM_CYC; // [R19]
                end else if (w) begin
                    state_nxt = FBPE_IDLE;                                  // [R08] [R06]
                    abort_ev  = 1'b1;
                end
            end
            FBPE_PBUSY: begin
                // Done outranks suspend; a zero count never ends
                if (tmr_done) begin
                    state_nxt = FBPE_IDLE;                                  // [R09]
                end else if (cmd_susp) begin
                    state_nxt = FBPE_PSUSP;                                 // [R23] [R12]
                end
            end
            FBPE_PSUSP: begin
                if (cmd_resume) begin
                    state_nxt = FBPE_PBUSY;                                 // [R12]
                end
            end
            FBPE_ESETUP: begin
                if (cmd_se && prot_hit) begin
                    state_nxt   = FBPE_IDLE;                                // [R14]
                    prot_ev     = 1'b1;
                    acc_prot_ev = lnk.boost_hv;                             // [R21]
                end else if (cmd_se) begin
                    state_nxt = FBPE_SEBUSY;                                // [R13]
                    tmr_load  = 1'b1;
                    tmr_val   = lnk.boost_hv ? `FBPE_SE_ACC_CYC : `FBPE_SE_CYC;
                end else if (cmd_ce && any_prot) begin
                    state_nxt = FBPE_IDLE;                                  // [R17]
                    prot_ev   = 1'b1;
                end else if (cmd_ce) begin
                    state_nxt = FBPE_CEBUSY;                                // [R16]
                    tmr_load  = 1'b1;
                    tmr_val   = `FBPE_CE_CYC;
                end else if (w) begin
                    state_nxt = FBPE_IDLE;
                end
            end
            FBPE_SEBUSY: begin
                if (tmr_done) begin
                    state_nxt = FBPE_IDLE;
                end else if (cmd_susp) begin
                    state_nxt = FBPE_SESUSP;                                // [R15]
                end
            end
            FBPE_SESUSP: begin
                if (cmd_resume) begin
                    state_nxt = FBPE_SEBUSY;
                end
            end
            FBPE_CEBUSY: begin
                // No command stops a chip erase
                if (tmr_done) begin
                    state_nxt = FBPE_IDLE;                                  // [R18]
                end
            end
        endcase
        if (lnk.hw_reset) begin
            state_nxt = FBPE_IDLE;                                          // [R15] [R18]
            tmr_load  = 1'b0;
        end
    end

    // Operation timer, frozen while suspended
    fbpe_timer u_timer (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .load     (tmr_load),
        .load_val (tmr_val),
        .run      (busy_st),
        .done     (tmr_done)
    );

    // State and status flags; a set outranks a clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= FBPE_IDLE;
            pfail_r <= 1'b0;
            efail_r <= 1'b0;
            prot_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (abort_ev) begin
                pfail_r <= 1'b1;                                            // [R05]
            end else if (cmd_clr && state_r == FBPE_IDLE) begin
                pfail_r <= 1'b0;                                            // [R07]
            end
            if (prot_ev) begin
                prot_r <= 1'b1;                                             // [R14]
            end else if (cmd_clr && state_r == FBPE_IDLE) begin
                prot_r <= 1'b0;
            end
            if (acc_prot_ev) begin
                efail_r <= 1'b1;                                            // [R21]
            end else if (cmd_clr && state_r == FBPE_IDLE) begin
                efail_r <= 1'b0;
            end
        end
    end

    // Buffer bookkeeping
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_r <= '0;
            loads_r <= '0;
            page_r  <= '0;
            sec_r   <= '0;
            vld_r   <= '0;
        end else if (state_r == FBPE_IDLE && (cmd_buf || cmd_esetup)) begin
            loads_r <= '0;
            vld_r   <= '0;
            sec_r   <= wr_sec;
        end else if (state_r == FBPE_BCNT && w) begin
            count_r <= lnk.wr_data[`FBPE_CNT_W-1:0];                        // [R03]
        end else if (state_r == FBPE_BLOAD && w) begin
            loads_r <= loads_r + 1'b1;
            vld_r[lnk.wr_addr[`FBPE_PAGE_LO-1:0]] <= 1'b1;
            if (first_load) begin
                page_r <= lnk.wr_addr[`FBPE_PAGE_HI:`FBPE_PAGE_LO];         // [R04]
                sec_r  <= wr_sec;
            end
        end else if (state_r == FBPE_ESETUP && w) begin
            sec_r <= wr_sec;
        end
    end

    // Buffer words, any order within the page
    always_ff @(posedge hclk) begin
        if (state_r == FBPE_BLOAD && w) begin
            buf_r[lnk.wr_addr[`FBPE_PAGE_LO-1:0]] <= lnk.wr_data;           // [R04]
        end
    end

    // Array window: sector index and low offset bits; upper offset bits alias
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < `FBPE_MEM_WORDS; i++) begin
                mem_r[i] <= '1;
            end
        end else if (tmr_done && state_r == FBPE_PBUSY && !lnk.hw_reset) begin
            for (int i = 0; i < `FBPE_BUF_WORDS; i++) begin
                if (vld_r[i]) begin
                    mem_r[{sec_r, 4'(i)}] <= mem_r[{sec_r, 4'(i)}] & buf_r[i]; // [R11]
                end
            end
        end else if (tmr_done && state_r == FBPE_SEBUSY && !lnk.hw_reset) begin
            for (int i = 0; i < `FBPE_MEM_WORDS / `FBPE_NSEC; i++) begin
                mem_r[{sec_r, 4'(i)}] <= '1;                                // [R13]
            end
        end else if (tmr_done && state_r == FBPE_CEBUSY && !lnk.hw_reset) begin
            for (int i = 0; i < `FBPE_MEM_WORDS; i++) begin
                mem_r[i] <= '1;                                             // [R16]
            end
        end
    end

    // Registered outputs toward the link and user side
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_r  <= 8'h80;
            rd_data_r <= '0;
            cfg_en_r  <= 1'b1;
        end else begin
            status_r <= '0;
            status_r[`FBPE_ST_RDY]   <= !busy_st;
            status_r[`FBPE_ST_ESUSP] <= state_r == FBPE_SESUSP;
            status_r[`FBPE_ST_EFAIL] <= efail_r;
            status_r[`FBPE_ST_PFAIL] <= pfail_r;
            status_r[`FBPE_ST_PSUSP] <= state_r == FBPE_PSUSP;
            status_r[`FBPE_ST_PROT]  <= prot_r;
            rd_data_r <= mem_r[{lnk.rd_addr[`FBPE_SEC_HI:`FBPE_SEC_LO], lnk.rd_addr[3:0]}];
            cfg_en_r  <= !(state_r inside {FBPE_PBUSY, FBPE_PSUSP});        // [R10]
        end
    end

    assign lnk.status    = status_r;
    assign lnk.rd_data   = rd_data_r;
    assign lnk.busy      = !status_r[`FBPE_ST_RDY];
    assign secure_cfg_en = cfg_en_r;
endmodule // fbpe_dev

// ==== logic/fbpe_host.sv ====
// Memory controller end: AHB-Lite slave registers turned into link cycles.
// Assumes one AHB master on hclk; the slave never inserts wait states.
`timescale 1ns/1ps
`include "fbpe_map.svh"
module fbpe_host
    import fbpe_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    fbpe_if.host             lnk
);
    logic        ap_wr_r;           // Write pending in data phase
    logic [7:0]  ap_addr_r;         // Its register offset
    fbpe_addr_t  addr_r;            // Command and read address
    fbpe_word_t  data_r;            // Last command data
    logic        stb_r;             // Command strobe
    logic        boost_r;           // Boost level request
    logic        hwrst_r;           // Hardware reset pulse
    logic [7:0]  bcnt_r;            // Cycles since boost raised, held at 25 once the settle count is reached
    logic [31:0] hrdata_r;          // Read data for the data phase

    // Address phase decode; hsize is always a word here
    wire ap_take  = hsel && htrans[1] && hready;
    wire brdy     = bcnt_r == 8'(`FBPE_BOOST_CYC);
    wire dp_data  = ap_wr_r && ap_addr_r == `FBPE_REG_DATA;
    wire dp_ctrl  = ap_wr_r && ap_addr_r == `FBPE_REG_CTRL;
    wire dp_addr  = ap_wr_r && ap_addr_r == `FBPE_REG_ADDR;
    wire [31:0] stat_word = {22'h0, lnk.busy, brdy, lnk.status};
    wire [31:0] rd_mux =
        (haddr[7:0] == `FBPE_REG_ADDR) ? {9'h0, addr_r} :
        (haddr[7:0] == `FBPE_REG_DATA) ? {16'h0, data_r} :
        (haddr[7:0] == `FBPE_REG_CTRL) ? {31'h0, boost_r} :
        (haddr[7:0] == `FBPE_REG_STAT) ? stat_word :
        (haddr[7:0] == `FBPE_REG_RDAT) ? {16'h0, lnk.rd_data} : 32'h0;

    // Bus phases and read data capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_wr_r   <= 1'b0;
            ap_addr_r <= '0;
            hrdata_r  <= '0;
        end else begin
            ap_wr_r <= ap_take && hwrite;
            if (ap_take) begin
                ap_addr_r <= haddr[7:0];
                hrdata_r  <= hwrite ? 32'h0 : rd_mux;
            end
        end
    end

    // Registers and link cycles; writing data fires one command cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_r  <= '0;
            data_r  <= '0;
            stb_r   <= 1'b0;
            boost_r <= 1'b0;
            hwrst_r <= 1'b0;
        end else begin
            stb_r   <= dp_data;
            hwrst_r <= dp_ctrl && hwdata[`FBPE_CTRL_HWRST];
            if (dp_addr) begin
                addr_r <= hwdata[`FBPE_AW-1:0];
            end
            if (dp_data) begin
                data_r <= hwdata[`FBPE_DW-1:0];
            end
            if (dp_ctrl) begin
                boost_r <= hwdata[`FBPE_CTRL_BOOST];
            end
        end
    end

    // Boost settle time before an accelerated erase may be sent
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bcnt_r <= '0;
        end else if (!boost_r) begin
            bcnt_r <= '0;
        end else if (!brdy) begin
            bcnt_r <= bcnt_r + 1'b1;                                        // [R20]
        end
    end

    assign hreadyout    = 1'b1;
    assign hresp        = 1'b0;
    assign hrdata       = hrdata_r;
    assign lnk.wr_stb   = stb_r;
    assign lnk.wr_addr  = addr_r;
    assign lnk.wr_data  = data_r;
    assign lnk.hw_reset = hwrst_r;
    assign lnk.boost_hv = boost_r;
    assign lnk.rd_addr  = addr_r;
endmodule // fbpe_host

// ==== verification/fbpe_link_props.sv ====
// Checker on the link between the two ends.
// Assumes one clock; tb_top instantiates it beside the link.
`timescale 1ns/1ps
`include "fbpe_map.svh"
module fbpe_link_props
    import fbpe_pkg::*;
(
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic       wr_stb,
    input wire fbpe_addr_t wr_addr,
    input wire fbpe_word_t wr_data,
    input wire logic       hw_reset,
    input wire logic [7:0] status,
    input wire logic       busy
);
    wire logic [11:0] offs = wr_addr[11:0]; // In-sector offset
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    AST_BUSY_MIRROR: assert property (busy == !status[7])
        else $error("busy mismatch");
    AST_START_CAUSE: assert property ($fell(status[7]) |-> $past(wr_stb, 2))
        else $error("busy without command");
    AST_BUSY_HOLDS: assert property (
        $fell(status[7]) && !hw_reset ##1 !hw_reset [*8] |-> !status[7])
        else $error("busy too short");
    AST_HWRST_IDLE: assert property (hw_reset |-> ##2 status[7])
        else $error("reset left bank busy");
    AST_ABORT_CAUSE: assert property ($rose(status[4]) |-> $past(wr_stb, 2))
        else $error("abort without command");
    AST_PROT_CAUSE: assert property (
        $rose(status[1]) |-> $past(wr_stb, 2) && $past(offs, 2) == `FBPE_OFF_CNT)
        else $error("refusal without erase");
    AST_CLEAR_CAUSE: assert property (
        $fell(status[4]) || $fell(status[1]) |-> $past(wr_data, 2) == `FBPE_CMD_CLR_STS)
        else $error("flags cleared without clear");
    AST_ACC_PROT: assert property ($rose(status[5]) |-> status[1])
        else $error("boost refusal lacks flag");
endmodule // fbpe_link_props

// ==== verification/tb_top.sv ====
// Bench: AHB master drives the controller end.
// Assumes the shipped timing defines; about 7k cycles.
`timescale 1ns/1ps
`include "fbpe_map.svh"
module tb_top;
    import fbpe_pkg::*;
    localparam fbpe_addr_t S1 = 23'h080000; // Sector 1 base
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, dph_rd = 0;
    logic        hreadyout, hresp, secure_cfg_en;
    logic [1:0]  htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, exp_q[$];
    logic [15:0] prot = 0, seed = 16'h003f, ex = 16'hffff;
    int          miscompares = 0, tests_run = 0;
    fbpe_if lnk ();
    fbpe_host u_fbpe_host (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .lnk(lnk));
    fbpe_dev u_fbpe_dev (.hclk, .hresetn, .lnk(lnk), .prot_sectors(prot), .secure_cfg_en);
    fbpe_link_props u_fbpe_link_props (.hclk, .hresetn, .wr_stb(lnk.wr_stb),
        .wr_addr(lnk.wr_addr), .wr_data(lnk.wr_data), .hw_reset(lnk.hw_reset),
        .status(lnk.status), .busy(lnk.busy));
    initial forever #20 hclk = ~hclk;
    task chk(logic [31:0] s, e);
        tests_run++;
        if (s !== e) begin
            $display("Error t=%0t seen=%h exp=%h", $time, s, e);
            miscompares++;
        end
    endtask
    task close_out;
        if (miscompares == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Bounded wait; a hang counts as a mismatch
    task automatic wt(ref logic s, input logic v);
        for (int n = 0; n < 5000 && s !== v; n++) @(posedge hclk);
        if (s !== v) begin
            miscompares++;
            close_out;
        end
    endtask
    // Single word transfer; a read notes its expected word
    task ahb(logic w, logic [31:0] a, d);
        if (!w) exp_q.push_back(d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge hclk);
        wt(hreadyout, 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= w ? d : 32'h0;
        dph_rd <= !w;
        @(posedge hclk);
        wt(hreadyout, 1'b1);
        dph_rd <= 1'b0;
    endtask
    // Oldest note against read data at data phase end
    always @(posedge hclk)
        if (dph_rd && hreadyout === 1'b1) chk(hrdata, exp_q.pop_front());
    function automatic fbpe_word_t xs();
        seed ^= seed << 7;
        seed ^= seed >> 9;
        seed ^= seed << 8;
        return seed;
    endfunction
    // Link write; three idle cycles let status settle
    task cmd(fbpe_addr_t a, fbpe_word_t d);
        ahb(1'b1, `FBPE_REG_ADDR, {9'h0, a});
        ahb(1'b1, `FBPE_REG_DATA, {16'h0, d});
        repeat (3) @(posedge hclk);
    endtask
    task two(fbpe_word_t c1, c2);
        cmd(S1 | 23'h555, c1);
        cmd(S1 | 23'h2aa, c2);
    endtask
    task clr;
        cmd(23'h0, `FBPE_CMD_CLR_STS);
        ahb(1'b0, `FBPE_REG_STAT, 32'h80);
    endtask
    task rda;
        ahb(1'b1, `FBPE_REG_ADDR, {9'h0, S1 | 23'h3});
        @(posedge hclk);
        ahb(1'b0, `FBPE_REG_RDAT, {16'h0, ex});
    endtask
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(1'b0, `FBPE_REG_STAT, 32'h80);
        // Same word twice with random data, loads out of order
        repeat (2) begin
            seed = xs();
            ex &= seed;
            two(`FBPE_CMD_BUF, 16'h1);
            cmd(S1 | 23'h3, seed);
            cmd(S1 | 23'h1, 16'hffff);
            cmd(S1 | 23'h555, `FBPE_CMD_COMMIT);
            ahb(1'b0, `FBPE_REG_STAT, 32'h200);
            chk({31'h0, secure_cfg_en}, 32'h0);
            cmd(S1, `FBPE_CMD_SUSP);
            ahb(1'b0, `FBPE_REG_STAT, 32'h84);
            cmd(S1, `FBPE_CMD_RESUME);
            wt(lnk.busy, 1'b0);
            rda;
        end
        // Count too big, page crossed, stray command after last load
        for (int c = 0; c < 3; c++) begin
            two(`FBPE_CMD_BUF, c == 0 ? 16'h20 : 16'(2 - c));
            if (c > 0) cmd(S1 | 23'h1, 16'hffff);
            if (c == 1) cmd(S1 | 23'h21, 16'hffff);
            if (c == 2) cmd(S1 | 23'h555, `FBPE_CMD_RD_STS);
            ahb(1'b0, `FBPE_REG_STAT, 32'h90);
            clr;
        end
        // Refused erases: plain, boosted, whole chip
        prot <= 16'h3;
        for (int e = 0; e < 3; e++) begin
            ahb(1'b1, `FBPE_REG_CTRL, {31'h0, e == 1});
            repeat (30) @(posedge hclk);
            two(`FBPE_CMD_ESETUP, e == 2 ? `FBPE_CMD_CHIP_ERS : `FBPE_CMD_SEC_ERS);
            ahb(1'b0, `FBPE_REG_STAT, e == 1 ? 32'h1a2 : 32'h82);
            ahb(1'b1, `FBPE_REG_CTRL, 32'h0);
            clr;
        end
        // Erase cut by hardware reset, then full erases
        prot <= 16'h0;
        two(`FBPE_CMD_ESETUP, `FBPE_CMD_SEC_ERS);
        two(`FBPE_CMD_BUF, 16'h0);
        ahb(1'b1, `FBPE_REG_CTRL, 32'h2);
        repeat (3) @(posedge hclk);
        ahb(1'b0, `FBPE_REG_STAT, 32'h80);
        rda;
        two(`FBPE_CMD_ESETUP, `FBPE_CMD_SEC_ERS);
        two(`FBPE_CMD_BUF, 16'h0);
        wt(lnk.busy, 1'b0);
        ex = 16'hffff;
        rda;
        two(`FBPE_CMD_ESETUP, `FBPE_CMD_CHIP_ERS);
        ahb(1'b0, `FBPE_REG_STAT, 32'h200);
        wt(lnk.busy, 1'b0);
        ahb(1'b0, `FBPE_REG_STAT, 32'h80);
        close_out;
    end
endmodule // tb_top
